// *** logic/ssp_supply_port.sv ***
// two-wire slave port and system register of the antenna supply control
`timescale 1ns/1ps
`include "ssp_defs.svh"

// Summary of operation
// - address byte 0x10 writes, 0x11 reads
// - start, address+ack, data+ack, then stop
// - eight-bit register, upper six writable only
// - register clears to zero at power-on
// - write direction stores data into writable bits
// - boost and select bits choose regulator level
// - tone force on, else keying input gates
// - transmit select picks transmit or receive output
// - limit style: zero pulsed, one static clamp
// - power enable low disables regulator, level, tone and tx/rx outputs
// - read direction shifts register out MSB first
// - master ack continues read, nack ends it
// - writable bits read back as last written
// - flags report over-temperature and overload
// - lockout ignores bus and zeroes writable bits
// - bus operative only after lockout releases
// - address base 0001000, four strap selectable
// - acknowledge each byte, none under lockout
// - pulsed overload: off, retry tenth, flag
module ssp_supply_port #(
  parameter int P_TOFF_CYCLES = (`SSP_CLK_HZ / 1000) * `SSP_TOFF_MS,
  parameter int P_TON_CYCLES  = P_TOFF_CYCLES / `SSP_TON_DIV
) (
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_clk_en,
  // serial bus pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe_n,
  input  wire logic [1:0] i_addr_select,
  // analog monitors and tone keying
  input  wire logic       i_undervoltage_lockout,
  input  wire logic       i_over_temperature,
  input  wire logic       i_overload,
  input  wire logic       i_tone_keying_input,
  // regulator controls
  output logic            o_regulator_on,
  output logic [1:0]      o_level_code,
  output logic            o_tone_on,
  output logic            o_transmit_output,
  output logic            o_receive_output,
  output logic            o_static_clamp,
  output logic            o_overload_shutdown,
  output logic [7:0]      o_system_control_status
);

  // ------------------------------------------------------------------
  // pin synchronisation
  // ------------------------------------------------------------------
  logic [7:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       uvlo_s;
  logic       otemp_s;
  logic       ovl_s;
  logic       key_s;
  logic [1:0] sel_s;

  ssp_sync2 #(.WIDTH(8)) u_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_clk_en(i_clk_en),
    .i_async ({i_scl, i_sda, i_undervoltage_lockout, i_over_temperature,
               i_overload, i_tone_keying_input, i_addr_select}),
    .o_sync  (pins_s)
  );

  assign {scl_s, sda_s, uvlo_s, otemp_s, ovl_s, key_s, sel_s} = pins_s;

  // ------------------------------------------------------------------
  // bus state
  // ------------------------------------------------------------------
  ssp_pkg::ssp_bus_state_type st_q;
  ssp_pkg::ssp_bus_state_type st_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic       rw_q;
  logic       rw_d;
  logic       drv_q;
  logic       drv_d;
  logic [5:0] ctrl_q;
  logic [5:0] ctrl_d;
  logic       mack_q;
  logic       mack_d;
  logic [1:0] asel_q;
  logic [1:0] asel_d;
  logic       scl_p_q;
  logic       sda_p_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic [6:0] dev_addr;
  logic [7:0] reg_val;
  logic       olf_q;

  assign scl_rise   = scl_s & ~scl_p_q;
  assign scl_fall   = ~scl_s & scl_p_q;
  assign start_cond = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_cond  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign dev_addr   = `SSP_DEV_ADDR_BASE | {5'h00, asel_q};
  assign reg_val    = {ctrl_q, otemp_s, olf_q};

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    shift_d = shift_q;
    rw_d    = rw_q;
    drv_d   = drv_q;
    ctrl_d  = ctrl_q;
    mack_d  = mack_q;
    asel_d  = asel_q;
    // strap is static; follow it only between transfers
    if (st_q == ssp_pkg::SSP_IDLE) begin
      asel_d = sel_s;
    end
    if (uvlo_s) begin
      st_d   = ssp_pkg::SSP_IDLE;
      drv_d  = 1'b0;
      ctrl_d = `SSP_CTRL_RESET;
    end else if (start_cond) begin
      st_d  = ssp_pkg::SSP_ADDR;
      cnt_d = 4'h0;
      drv_d = 1'b0;
    end else if (stop_cond) begin
      st_d  = ssp_pkg::SSP_IDLE;
      drv_d = 1'b0;
    end else begin
      case (st_q)
        ssp_pkg::SSP_ADDR, ssp_pkg::SSP_WRITE: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s};
            cnt_d   = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == `SSP_BYTE_BITS) begin
            if (st_q == ssp_pkg::SSP_WRITE) begin
              st_d  = ssp_pkg::SSP_WRITE_ACK;
              drv_d = 1'b1;
            end else if (shift_q[7:1] == dev_addr) begin
              st_d  = ssp_pkg::SSP_ADDR_ACK;
              drv_d = 1'b1;
              rw_d  = shift_q[0];
            end else begin
              st_d = ssp_pkg::SSP_IGNORE;
            end
          end
        end
        ssp_pkg::SSP_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            if (rw_q) begin
              st_d    = ssp_pkg::SSP_READ;
              shift_d = reg_val;
              drv_d   = ~reg_val[7];
            end else begin
              st_d  = ssp_pkg::SSP_WRITE;
              drv_d = 1'b0;
            end
          end
        end
        ssp_pkg::SSP_WRITE_ACK: begin
          if (scl_fall) begin
            // flag positions of the byte are dropped
            ctrl_d = shift_q[7:2];
            drv_d  = 1'b0;
            cnt_d  = 4'h0;
            st_d   = ssp_pkg::SSP_WRITE;
          end
        end
        ssp_pkg::SSP_READ: begin
          if (scl_fall) begin
            if (cnt_q == `SSP_LAST_READ_BIT) begin
              st_d  = ssp_pkg::SSP_READ_ACK;
              drv_d = 1'b0;
            end else begin
              cnt_d   = cnt_q + 4'h1;
              shift_d = {shift_q[6:0], 1'b0};
              drv_d   = ~shift_q[6];
            end
          end
        end
        ssp_pkg::SSP_READ_ACK: begin
          if (scl_rise) begin
            mack_d = ~sda_s;
          end else if (scl_fall) begin
            if (mack_q) begin
              st_d    = ssp_pkg::SSP_READ;
              shift_d = reg_val;
              drv_d   = ~reg_val[7];
              cnt_d   = 4'h0;
            end else begin
              st_d = ssp_pkg::SSP_IGNORE;
            end
          end
        end
        ssp_pkg::SSP_IDLE, ssp_pkg::SSP_IGNORE: begin
          drv_d = 1'b0;
        end
        default: begin
          st_d  = ssp_pkg::SSP_IDLE;
          drv_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q    <= ssp_pkg::SSP_IDLE;
      cnt_q   <= 4'h0;
      shift_q <= `SSP_REG_RESET;
      rw_q    <= 1'b0;
      drv_q   <= 1'b0;
      ctrl_q  <= `SSP_CTRL_RESET;
      mack_q  <= 1'b0;
      asel_q  <= 2'h0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (i_clk_en) begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      rw_q    <= rw_d;
      drv_q   <= drv_d;
      ctrl_q  <= ctrl_d;
      mack_q  <= mack_d;
      asel_q  <= asel_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // open drain: only ever pull low
  assign o_sda_out  = 1'b0;
  assign o_sda_oe_n = ~drv_q;

  // ------------------------------------------------------------------
  // overload protection
  // ------------------------------------------------------------------
  ssp_pkg::ssp_prot_state_type prot_q;
  ssp_pkg::ssp_prot_state_type prot_d;
  logic [24:0] timer_q;
  logic [24:0] timer_d;
  logic        seen_q;
  logic        seen_d;
  logic        olf_d;
  logic        powered;
  logic        pulsed;

  assign powered = ctrl_q[`SSP_BIT_POWER_EN - 2] & ~otemp_s;
  assign pulsed  = ~ctrl_q[`SSP_BIT_LIMIT_STYLE - 2];

  always_comb begin
    prot_d  = prot_q;
    timer_d = timer_q;
    seen_d  = seen_q;
    olf_d   = olf_q;
    if (!powered || !pulsed) begin
      // static clamp or power off: flag follows the clamp level while powered, else clears
      prot_d = ssp_pkg::SSP_PROT_NORMAL;
      olf_d  = powered & ovl_s;
    end else begin
      case (prot_q)
        ssp_pkg::SSP_PROT_NORMAL: begin
          olf_d = 1'b0;
          if (ovl_s) begin
            prot_d  = ssp_pkg::SSP_PROT_OFF;
            timer_d = 25'(P_TOFF_CYCLES - 1);
            olf_d   = 1'b1;
          end
        end
        ssp_pkg::SSP_PROT_OFF: begin
          olf_d = 1'b1;
          if (timer_q == 25'h0) begin
            prot_d  = ssp_pkg::SSP_PROT_RETRY;
            timer_d = 25'(P_TON_CYCLES - 1);
            seen_d  = 1'b0;
          end else begin
            timer_d = timer_q - 25'h1;
          end
        end
        ssp_pkg::SSP_PROT_RETRY: begin
          seen_d = seen_q | ovl_s;
          if (timer_q == 25'h0) begin
            if (seen_q || ovl_s) begin
              prot_d  = ssp_pkg::SSP_PROT_OFF;
              timer_d = 25'(P_TOFF_CYCLES - 1);
            end else begin
              prot_d = ssp_pkg::SSP_PROT_NORMAL;
              olf_d  = 1'b0;
            end
          end else begin
            timer_d = timer_q - 25'h1;
          end
        end
        default: begin
          prot_d = ssp_pkg::SSP_PROT_NORMAL;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prot_q  <= ssp_pkg::SSP_PROT_NORMAL;
      timer_q <= 25'h0;
      seen_q  <= 1'b0;
      olf_q   <= 1'b0;
    end else if (i_clk_en) begin
      prot_q  <= prot_d;
      timer_q <= timer_d;
      seen_q  <= seen_d;
      olf_q   <= olf_d;
    end
  end

  // ------------------------------------------------------------------
  // regulator outputs
  // ------------------------------------------------------------------
  logic tone_req;

  assign o_overload_shutdown = (prot_q == ssp_pkg::SSP_PROT_OFF);
  assign o_regulator_on      = powered & ~o_overload_shutdown;
  assign o_level_code        = powered ? ctrl_q[2:1] : 2'h0;
  assign tone_req            = ctrl_q[`SSP_BIT_TONE_FORCE - 2] | key_s;
  assign o_tone_on           = o_regulator_on & tone_req;
  assign o_transmit_output   = o_regulator_on & ctrl_q[4];
  assign o_receive_output    = o_regulator_on & ~ctrl_q[4];
  assign o_static_clamp      = ~pulsed;
  assign o_system_control_status = reg_val;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence s_ack_end;
    scl_fall && !uvlo_s && !start_cond && !stop_cond;
  endsequence

  property p_uvlo_clear;
    @(posedge i_clock) disable iff (!i_rst_n)
    uvlo_s && i_clk_en |=> ctrl_q == 6'h00 && st_q == ssp_pkg::SSP_IDLE;
  endproperty
  a_uvlo_clear: assert property (p_uvlo_clear)
    else $error("register not cleared under lockout");

  property p_uvlo_no_ack;
    @(posedge i_clock) disable iff (!i_rst_n)
    uvlo_s && $past(uvlo_s) && $past(i_clk_en) |-> o_sda_oe_n;
  endproperty
  a_uvlo_no_ack: assert property (p_uvlo_no_ack)
    else $error("data line driven under lockout");

  property p_power_gate;
    @(posedge i_clock) disable iff (!i_rst_n)
    !ctrl_q[0] |-> !o_regulator_on && !o_tone_on && o_level_code == 2'h0;
  endproperty
  a_power_gate: assert property (p_power_gate)
    else $error("power block active while disabled");

  property p_tone_force;
    @(posedge i_clock) disable iff (!i_rst_n)
    o_regulator_on && ctrl_q[3] |-> o_tone_on;
  endproperty
  a_tone_force: assert property (p_tone_force)
    else $error("forced tone not on");

  property p_write_commit;
    @(posedge i_clock) disable iff (!i_rst_n)
    st_q == ssp_pkg::SSP_WRITE_ACK && i_clk_en ##0 s_ack_end
      |=> ctrl_q == $past(shift_q[7:2]) && o_sda_oe_n;
  endproperty
  a_write_commit: assert property (p_write_commit)
    else $error("write byte not committed");

  property p_read_first;
    @(posedge i_clock) disable iff (!i_rst_n)
    st_q == ssp_pkg::SSP_ADDR_ACK && rw_q && i_clk_en ##0 s_ack_end
      |=> st_q == ssp_pkg::SSP_READ && o_sda_oe_n == $past(reg_val[7]);
  endproperty
  a_read_first: assert property (p_read_first)
    else $error("read MSB not presented");

  property p_addr_ack;
    @(posedge i_clock) disable iff (!i_rst_n)
    st_q == ssp_pkg::SSP_ADDR && cnt_q == 4'h8 && i_clk_en
      && shift_q[7:1] == dev_addr ##0 s_ack_end |=> !o_sda_oe_n;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");

  property p_pulsed_trip;
    @(posedge i_clock) disable iff (!i_rst_n)
    prot_q == ssp_pkg::SSP_PROT_NORMAL && powered && pulsed && ovl_s
      && i_clk_en ##1 powered && pulsed |-> olf_q && o_overload_shutdown;
  endproperty
  a_pulsed_trip: assert property (p_pulsed_trip)
    else $error("pulsed overload did not trip");

  property p_otf_flag;
    @(posedge i_clock) disable iff (!i_rst_n)
    otemp_s |-> o_system_control_status[1] && !o_regulator_on;
  endproperty
  a_otf_flag: assert property (p_otf_flag)
    else $error("over-temperature not reported");

endmodule

// *** include/ssp_defs.svh ***
// constants for the supply control port: bit positions, reset, timing
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// ------------------------------------------------------------------
// bus address
// ------------------------------------------------------------------
`define SSP_DEV_ADDR_BASE   7'h08
`define SSP_BYTE_BITS       4'h8
`define SSP_LAST_READ_BIT   4'h7

// ------------------------------------------------------------------
// system register layout
// ------------------------------------------------------------------
`define SSP_BIT_LIMIT_STYLE 7
`define SSP_BIT_TX_SELECT   6
`define SSP_BIT_TONE_FORCE  5
`define SSP_BIT_CABLE_BOOST 4
`define SSP_BIT_VOLT_SELECT 3
`define SSP_BIT_POWER_EN    2
`define SSP_BIT_OVER_TEMP   1
`define SSP_BIT_OVERLOAD    0
`define SSP_REG_RESET       8'h00
`define SSP_CTRL_RESET      6'h00

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define SSP_CLK_HZ          25000000
`define SSP_TOFF_MS         900
`define SSP_TON_DIV         10

`endif

// *** include/ssp_pkg.sv ***
// types for the supply control port
package ssp_pkg;

  // ----------------------------------------------------------------
  // serial bus states
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    SSP_IDLE      = 8'h01,
    SSP_ADDR      = 8'h02,
    SSP_ADDR_ACK  = 8'h04,
    SSP_WRITE     = 8'h08,
    SSP_WRITE_ACK = 8'h10,
    SSP_READ      = 8'h20,
    SSP_READ_ACK  = 8'h40,
    SSP_IGNORE    = 8'h80
  } ssp_bus_state_type;

  // ----------------------------------------------------------------
  // pulsed overload protection states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SSP_PROT_NORMAL = 3'h1,
    SSP_PROT_OFF    = 3'h2,
    SSP_PROT_RETRY  = 3'h4
  } ssp_prot_state_type;

  // ----------------------------------------------------------------
  // regulator level code, {cable_boost, voltage_level_select}
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSP_LEVEL_13V25 = 2'h0,
    SSP_LEVEL_18V   = 2'h1,
    SSP_LEVEL_14V25 = 2'h2,
    SSP_LEVEL_19V5  = 2'h3
  } ssp_level_type;

endpackage

// *** logic/ssp_sync2.sv ***
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module ssp_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic             i_clk_en,
  // pins and synchronised levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // first stage feeds only the second stage
  always_comb begin
    meta_d = i_clk_en ? i_async : meta_q;
    sync_d = i_clk_en ? meta_q : sync_q;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;

endmodule

// *** dv/ssp_master_model.sv ***
// two-wire bus master model driving the supply control port
`timescale 1ns/1ps
module ssp_master_model (
  // bus pins, data line is open drain with a pull-up
  output logic      o_scl,
  output logic      o_sda_low,
  input  wire logic i_sda
);
  // ----------------------------------------------------------------
  // bus phases, 320 ns per clock, data set early in the low phase
  // ----------------------------------------------------------------
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // only called from idle after a stop, never as a repeated start
  task automatic start();
    #160;
    o_sda_low = 1'b1;
    #160;
    o_scl = 1'b0;
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    #160;
    o_scl = 1'b1;
    #160;
    o_sda_low = 1'b0;
    #160;
  endtask
  // low phase long enough for the slave's three-clock drive delay
  task automatic bit_io(input logic b, output logic s);
    o_sda_low = ~b;
    #160;
    o_scl = 1'b1;
    #80;
    s = i_sda;
    #80;
    o_scl = 1'b0;
  endtask
  // byte out msb first, returns the ninth-clock level
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, ack);
  endtask
  // ack asks for one more byte, nack ends the read
  task automatic get(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~more, s);
  endtask
endmodule

// *** dv/ssp_supply_port_tb.sv ***
// self-checking bench for the supply control port
`timescale 1ns/1ps
module ssp_supply_port_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic       clock;
  logic       rst_n;
  logic       scl, sda_low, sda_out, sda_oe_n;
  wire logic  sda;
  logic [1:0] addr_sel;
  logic       uvlo, hot, ovl, key;
  logic       reg_on, tone_on, tx_out, rx_out, clamp, shut;
  logic [1:0] level;
  logic [7:0] status;
  int         err_total;
  int         checks_done;
  typedef struct packed {
    logic [7:0] wr;
    logic       key;
    logic [7:0] st;
    logic [1:0] lvl;
    logic [4:0] outs;
  } ssp_row_type;
  // outs is {on, tone, tx, rx, clamp}
  ssp_row_type rows [5] = '{
    '{8'h04, 1'b0, 8'h04, 2'h0, 5'h12},
    '{8'h4c, 1'b1, 8'h4c, 2'h1, 5'h1c},
    '{8'hb4, 1'b0, 8'hb4, 2'h2, 5'h1b},
    '{8'hdf, 1'b0, 8'hdc, 2'h3, 5'h15},
    '{8'hfb, 1'b1, 8'hf8, 2'h0, 5'h01}};

  assign sda = ~(sda_low | ~sda_oe_n);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  ssp_supply_port #(
    .P_TOFF_CYCLES(200),
    .P_TON_CYCLES (20)
  ) i_ssp_supply_port (
    .i_clock(clock), .i_rst_n(rst_n), .i_clk_en(1'b1),
    .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
    .o_sda_oe_n(sda_oe_n), .i_addr_select(addr_sel),
    .i_undervoltage_lockout(uvlo), .i_over_temperature(hot),
    .i_overload(ovl), .i_tone_keying_input(key),
    .o_regulator_on(reg_on), .o_level_code(level),
    .o_tone_on(tone_on), .o_transmit_output(tx_out),
    .o_receive_output(rx_out), .o_static_clamp(clamp),
    .o_overload_shutdown(shut), .o_system_control_status(status)
  );
  ssp_master_model i_ssp_master_model (
    .o_scl(scl), .o_sda_low(sda_low), .i_sda(sda)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] s,
                     input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] ea);
    logic a1, a2;
    i_ssp_master_model.start();
    i_ssp_master_model.put(a, a1);
    i_ssp_master_model.put(d, a2);
    i_ssp_master_model.stop();
    chk("write acks", {6'h00, a1, a2}, {6'h00, ea});
  endtask
  task automatic rd(input logic [7:0] a, input int n, input logic [7:0] e);
    logic       a1;
    logic [7:0] d;
    i_ssp_master_model.start();
    i_ssp_master_model.put(a, a1);
    chk("read ack", {7'h00, a1}, 8'h00);
    for (int i = 0; i < n; i++) begin
      i_ssp_master_model.get(i < n - 1, d);
      chk("read byte", d, e);
    end
    i_ssp_master_model.stop();
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    #1_000_000;
    err_total++;
    conclude();
  end
  initial begin
    err_total = 0;
    checks_done = 0;
    {rst_n, uvlo, hot, ovl, key} = 5'h00;
    addr_sel = 2'h0;
    settle(10);
    rst_n = 1'b1;
    settle(6);
    chk("reset status", status, 8'h00);
    chk("sda out", {7'h00, sda_out}, 8'h00);
    rd(8'h11, 1, 8'h00);
    foreach (rows[i]) begin
      key = rows[i].key;
      wr(8'h10, rows[i].wr, 2'b00);
      chk("status", status, rows[i].st);
      chk("outputs", {3'h0, reg_on, tone_on, tx_out, rx_out, clamp},
          {3'h0, rows[i].outs});
      chk("level", {6'h00, level}, {6'h00, rows[i].lvl});
      rd(8'h11, 2, rows[i].st);
    end
    // foreign address is left alone until the strap selects it
    wr(8'h12, 8'h00, 2'b11);
    chk("status kept", status, 8'hf8);
    addr_sel = 2'h1;
    settle(4);
    wr(8'h12, 8'h3c, 2'b00);
    rd(8'h13, 1, 8'h3c);
    addr_sel = 2'h0;
    uvlo = 1'b1;
    settle(4);
    chk("lockout status", status, 8'h00);
    wr(8'h10, 8'h04, 2'b11);
    chk("lockout power", {7'h00, reg_on}, 8'h00);
    uvlo = 1'b0;
    settle(4);
    wr(8'h10, 8'h04, 2'b00);
    hot = 1'b1;
    settle(4);
    chk("hot status", status, 8'h06);
    chk("hot power", {7'h00, reg_on}, 8'h00);
    hot = 1'b0;
    // pulse far shorter than the off time, so one full cycle follows
    ovl = 1'b1;
    settle(6);
    ovl = 1'b0;
    chk("pulsed off", {6'h00, shut, reg_on}, 8'h02);
    chk("pulsed off flag", status, 8'h05);
    settle(204);
    chk("retry", {6'h00, shut, reg_on}, 8'h01);
    chk("retry flag", status, 8'h05);
    settle(30);
    chk("recovered", {6'h00, shut, reg_on}, 8'h01);
    chk("recovered flag", status, 8'h04);
    wr(8'h10, 8'h84, 2'b00);
    ovl = 1'b1;
    settle(6);
    chk("clamp mode", {6'h00, shut, clamp}, 8'h01);
    chk("clamp flag", status, 8'h85);
    ovl = 1'b0;
    settle(6);
    chk("clamp clear", status, 8'h84);
    conclude();
  end
endmodule
